/* common/slt_defs.svh */
/*
 * Constants for the serial link transmitter control registers: offsets, field
 * positions, reset values, pattern codes and sequence lengths.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef SLT_DEFS_SVH
`define SLT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SLT_OFF_CTRL1 8'h5f
`define SLT_OFF_CTRL2 8'h60
`define SLT_OFF_CTRL3 8'h61
`define SLT_OFF_CTRL4 8'h62
`define SLT_OFF_DID 8'h64

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SLT_RST_CTRL1 8'h14
`define SLT_RST_CTRL2 8'h10
`define SLT_RST_CTRL3 8'h00
// Identification value is arbitrary
`define SLT_DEVICE_ID 8'h5a

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SLT_C1_LINK_DIS 0
`define SLT_C1_FRAME_DIS 1
`define SLT_C1_ILAS_LO 2
`define SLT_C1_ILAS_HI 3
`define SLT_C1_MF_EN 4
`define SLT_C1_TRANSPORT 5
`define SLT_C1_TAIL_PN 6
`define SLT_C2_OUT_INV 1
`define SLT_C2_SYNC_INV 6
`define SLT_C3_PAT_LO 0
`define SLT_C3_PAT_HI 3
`define SLT_C3_INJ_LO 4
`define SLT_C3_INJ_HI 5

// ----------------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------------
`define SLT_ILAS_OFF 2'h0
`define SLT_ILAS_NORMAL 2'h1
`define SLT_ILAS_ALWAYS 2'h3
`define SLT_INJ_10B 2'h1
`define SLT_INJ_8B 2'h2
`define SLT_PAT_OFF 4'h0
`define SLT_PAT_CHECKER 4'h1
`define SLT_PAT_TOGGLE 4'h2
`define SLT_PAT_PN23 4'h3
`define SLT_PAT_PN9 4'h4
`define SLT_PAT_USER_REP 4'h5
`define SLT_PAT_USER_ONE 4'h6
`define SLT_PAT_RPAT 4'h8
`define SLT_PAT_PN15 4'hc

// ----------------------------------------------------------------------------
// Data path constants
// ----------------------------------------------------------------------------
`define SLT_WORD_W 16
`define SLT_CHECKER_A 16'haaaa
`define SLT_CHECKER_B 16'h5555
`define SLT_PRBS_SEED 23'h7fffff
`define SLT_ILAS_WORDS 8'h10
`define SLT_ILAS_MARK 8'h1c
`define SLT_RPAT_LEN 3'h7

`endif

/* common/slt_pkg.sv */
/*
 * Types shared by the serial link transmitter control logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package slt_pkg;

   // Link start-up sequencing
   typedef enum logic [1:0] {
      SEQ_OFF,
      SEQ_ALIGN,
      SEQ_DATA
   } slt_seq_t;

endpackage : slt_pkg

/* src/slt_skid_buffer.sv */
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps

module slt_skid_buffer #(
   parameter int WIDTH = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);

   logic [WIDTH-1:0] slot_reg [2];
   logic rdIdx_reg;
   logic wrIdx_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   assign inReady = (count_reg != 2'h2);
   assign outValid = (count_reg != 2'h0);
   assign outData = slot_reg[rdIdx_reg];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         slot_reg[0] <= '0;
         slot_reg[1] <= '0;
      end else if (push) begin
         slot_reg[wrIdx_reg] <= inData;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdIdx_reg <= 1'b0;
         wrIdx_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            wrIdx_reg <= ~wrIdx_reg;
         end
         if (pop) begin
            rdIdx_reg <= ~rdIdx_reg;
         end
         case ({push, pop})
            2'b10: count_reg <= count_reg + 2'h1;
            2'b01: count_reg <= count_reg - 2'h1;
            default: count_reg <= count_reg;
         endcase
      end
   end

endmodule : slt_skid_buffer

/* src/slt_link_tx_ctrl.sv */
/*
 * Control registers and word source of the serial link transmitter: alignment
 * sequence, test pattern generation, output inversion and link disable.
 * Assumes the serial control port decoder drives the register strobes on
 * ref_clk, and the lane serialiser drains laneData with valid/ready.
 */
`timescale 1ns/1ps
`include "slt_defs.svh"

module slt_link_tx_ctrl (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic [15:0] userPatternA,
   input wire logic [15:0] userPatternB,
   input wire logic [15:0] sampleData,
   input wire logic sampleValid,
   output logic sampleReady,
   output logic [15:0] laneData,
   output logic laneValid,
   input wire logic laneReady,
   output logic alignActive,
   output logic inject8b,
   output logic inject10b,
   output logic linkDisabled,
   output logic tailPnFill,
   output logic transportTest,
   output logic mfCharEnable,
   output logic frameCharDisable,
   output logic syncInvert
);

   // ---------------------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------------------
   logic [7:0] ctrl1_reg;
   logic [7:0] ctrl2_reg;
   logic [7:0] ctrl3_reg;
   logic [7:0] regRdData_reg;
   logic [7:0] rdNext;
   logic patWrite;

   assign patWrite = regWrEn && (regAddr == `SLT_OFF_CTRL3);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl1_reg <= `SLT_RST_CTRL1;
         ctrl2_reg <= `SLT_RST_CTRL2;
         ctrl3_reg <= `SLT_RST_CTRL3;
      end else if (regWrEn) begin
         // Reserved and identification offsets ignore writes
         case (regAddr)
            `SLT_OFF_CTRL1: ctrl1_reg <= regWrData;
            `SLT_OFF_CTRL2: ctrl2_reg <= regWrData;
            `SLT_OFF_CTRL3: ctrl3_reg <= regWrData;
            default: ;
         endcase
      end
   end

   always_comb begin
      case (regAddr)
         `SLT_OFF_CTRL1: rdNext = ctrl1_reg;
         `SLT_OFF_CTRL2: rdNext = ctrl2_reg;
         `SLT_OFF_CTRL3: rdNext = ctrl3_reg;
         `SLT_OFF_DID: rdNext = `SLT_DEVICE_ID;
         default: rdNext = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         regRdData_reg <= 8'h00;
      end else if (regRdEn) begin
         regRdData_reg <= rdNext;
      end
   end

   assign regRdData = regRdData_reg;

   // ---------------------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------------------
   logic [1:0] alignMode;
   logic [3:0] patCode;
   logic [1:0] injPoint;
   logic outInvert;
   logic testOn;

   assign alignMode = ctrl1_reg[`SLT_C1_ILAS_HI:`SLT_C1_ILAS_LO];
   assign patCode = ctrl3_reg[`SLT_C3_PAT_HI:`SLT_C3_PAT_LO];
   assign injPoint = ctrl3_reg[`SLT_C3_INJ_HI:`SLT_C3_INJ_LO];
   assign outInvert = ctrl2_reg[`SLT_C2_OUT_INV];
   assign linkDisabled = ctrl1_reg[`SLT_C1_LINK_DIS];
   assign frameCharDisable = ctrl1_reg[`SLT_C1_FRAME_DIS];
   assign mfCharEnable = ctrl1_reg[`SLT_C1_MF_EN];
   assign transportTest = ctrl1_reg[`SLT_C1_TRANSPORT];
   assign tailPnFill = ctrl1_reg[`SLT_C1_TAIL_PN];
   assign syncInvert = ctrl2_reg[`SLT_C2_SYNC_INV];
   assign inject10b = (injPoint == `SLT_INJ_10B);
   assign inject8b = (injPoint == `SLT_INJ_8B);

   always_comb begin
      case (patCode)
         `SLT_PAT_CHECKER, `SLT_PAT_TOGGLE, `SLT_PAT_PN23, `SLT_PAT_PN9, `SLT_PAT_PN15,
         `SLT_PAT_USER_REP, `SLT_PAT_USER_ONE: testOn = 1'b1;
         // The shared code means normal data unless 8-bit injection is chosen
         `SLT_PAT_RPAT: testOn = inject8b;
         default: testOn = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------------------
   // Start-up sequencing
   // ---------------------------------------------------------------------------
   slt_pkg::slt_seq_t seq_reg;
   logic [7:0] alignCnt_reg;
   logic accept;
   logic bufInReady;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         seq_reg <= slt_pkg::SEQ_OFF;
         alignCnt_reg <= 8'h00;
      end else begin
         case (seq_reg)
            slt_pkg::SEQ_OFF: begin
               alignCnt_reg <= 8'h00;
               if (!linkDisabled) begin
                  seq_reg <= (alignMode == `SLT_ILAS_OFF) ? slt_pkg::SEQ_DATA : slt_pkg::SEQ_ALIGN;
               end
            end
            slt_pkg::SEQ_ALIGN: begin
               if (linkDisabled) begin
                  seq_reg <= slt_pkg::SEQ_OFF;
               end else if (accept) begin
                  alignCnt_reg <= alignCnt_reg + 8'h01;
                  // Continuous mode leaves alignment only when the link is disabled
                  if (alignCnt_reg == `SLT_ILAS_WORDS - 8'h01 && alignMode != `SLT_ILAS_ALWAYS) begin
                     seq_reg <= slt_pkg::SEQ_DATA;
                  end
               end
            end
            slt_pkg::SEQ_DATA: begin
               if (linkDisabled) begin
                  seq_reg <= slt_pkg::SEQ_OFF;
               end else if (alignMode == `SLT_ILAS_ALWAYS) begin
                  seq_reg <= slt_pkg::SEQ_ALIGN;
               end
            end
            default: seq_reg <= slt_pkg::SEQ_OFF;
         endcase
      end
   end

   assign alignActive = (seq_reg == slt_pkg::SEQ_ALIGN);

   // ---------------------------------------------------------------------------
   // Test pattern generator
   // ---------------------------------------------------------------------------
   logic [22:0] prbs_reg;
   logic [22:0] prbsNext;
   logic phase_reg;
   logic [1:0] userSent_reg;
   logic [2:0] rpatIdx_reg;
   logic [15:0] patWord;
   logic [15:0] rpatWord;
   logic patValid;

   // Sixteen serial steps per word; new bits land in the low sixteen bits
   function automatic logic [22:0] prbsAdvance(input logic [22:0] s, input logic [3:0] code);
      logic [22:0] st;
      logic fb;
      st = s;
      for (int i = 0; i < 16; i++) begin
         case (code)
            `SLT_PAT_PN9: fb = st[8] ^ st[4];
            `SLT_PAT_PN15: fb = st[14] ^ st[13];
            default: fb = st[22] ^ st[17];
         endcase
         st = {st[21:0], fb};
      end
      return st;
   endfunction : prbsAdvance

   assign prbsNext = prbsAdvance(prbs_reg, patCode);

   // Fixed word cycle for the modified random pattern
   always_comb begin
      case (rpatIdx_reg)
         3'h0: rpatWord = 16'hbe_d7;
         3'h1: rpatWord = 16'h23_47;
         3'h2: rpatWord = 16'h6b_8f;
         3'h3: rpatWord = 16'hb3_14;
         3'h4: rpatWord = 16'h5e_fb;
         3'h5: rpatWord = 16'h35_59;
         3'h6: rpatWord = 16'h7d_a1;
         default: rpatWord = 16'hc6_e2;
      endcase
   end

   always_comb begin
      patValid = 1'b1;
      case (patCode)
         `SLT_PAT_CHECKER: patWord = phase_reg ? `SLT_CHECKER_B : `SLT_CHECKER_A;
         `SLT_PAT_TOGGLE: patWord = phase_reg ? 16'h0000 : 16'hffff;
         // The advanced state goes out, so the all-ones seed never reaches the lanes
         `SLT_PAT_PN23, `SLT_PAT_PN9, `SLT_PAT_PN15: patWord = prbsNext[15:0];
         `SLT_PAT_USER_REP: patWord = phase_reg ? userPatternB : userPatternA;
         `SLT_PAT_USER_ONE: begin
            patWord = userSent_reg[0] ? userPatternB : userPatternA;
            patValid = (userSent_reg != 2'h2);
         end
         `SLT_PAT_RPAT: patWord = rpatWord;
         default: patWord = 16'h0000;
      endcase
   end

   // A new pattern code restarts every sequence from its first word
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prbs_reg <= `SLT_PRBS_SEED;
         phase_reg <= 1'b0;
         userSent_reg <= 2'h0;
         rpatIdx_reg <= 3'h0;
      end else if (patWrite) begin
         prbs_reg <= `SLT_PRBS_SEED;
         phase_reg <= 1'b0;
         userSent_reg <= 2'h0;
         rpatIdx_reg <= 3'h0;
      end else if (accept && seq_reg == slt_pkg::SEQ_DATA && testOn) begin
         prbs_reg <= prbsNext;
         phase_reg <= ~phase_reg;
         rpatIdx_reg <= (rpatIdx_reg == `SLT_RPAT_LEN) ? 3'h0 : rpatIdx_reg + 3'h1;
         if (userSent_reg != 2'h2) begin
            userSent_reg <= userSent_reg + 2'h1;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Word source and output buffer
   // ---------------------------------------------------------------------------
   logic [15:0] srcWord;
   logic srcValid;

   always_comb begin
      case (seq_reg)
         slt_pkg::SEQ_ALIGN: begin
            srcWord = {`SLT_ILAS_MARK, alignCnt_reg};
            srcValid = !linkDisabled;
         end
         slt_pkg::SEQ_DATA: begin
            srcWord = testOn ? patWord : sampleData;
            // Gated at once, since the sequencer leaves this state one edge after the write
            srcValid = !linkDisabled && (testOn ? patValid : sampleValid);
         end
         default: begin
            srcWord = 16'h0000;
            srcValid = 1'b0;
         end
      endcase
   end

   assign accept = srcValid && bufInReady;
   assign sampleReady = bufInReady && (seq_reg == slt_pkg::SEQ_DATA) && !testOn && !linkDisabled;

   slt_skid_buffer #(
      .WIDTH(`SLT_WORD_W)
   ) u_buffer (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .inData(outInvert ? ~srcWord : srcWord),
      .inValid(srcValid),
      .inReady(bufInReady),
      .outData(laneData),
      .outValid(laneValid),
      .outReady(laneReady)
   );

endmodule : slt_link_tx_ctrl

/* testbench/slt_link_tx_ctrl_chk.sv */
/* Concurrent checks on the link control block ports.
   Assumes binding into slt_link_tx_ctrl; one clock, async active-low reset. */
`timescale 1ns/1ps
module slt_link_tx_ctrl_chk (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic [15:0] laneData,
   input wire logic laneValid,
   input wire logic laneReady,
   input wire logic sampleReady,
   input wire logic alignActive,
   input wire logic inject8b,
   input wire logic inject10b,
   input wire logic linkDisabled,
   input wire logic frameCharDisable,
   input wire logic mfCharEnable,
   input wire logic transportTest,
   input wire logic tailPnFill,
   input wire logic syncInvert
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ctrl_bits_a: assert property (
      regWrEn && regAddr == 8'h5f |=> {tailPnFill, transportTest, mfCharEnable, frameCharDisable, linkDisabled}
      == {$past(regWrData[6:4]), $past(regWrData[1:0])}) else $error("control bits differ from write");
   inject_sel_a: assert property (
      regWrEn && regAddr == 8'h61 |=> inject8b == ($past(regWrData[5:4]) == 2'h2)
      && inject10b == ($past(regWrData[5:4]) == 2'h1)) else $error("injection decode wrong");
   id_read_a: assert property (
      regRdEn && regAddr == 8'h64 |=> regRdData == 8'h5a) else $error("identity read wrong");
   rsvd_read_a: assert property (
      regRdEn && regAddr == 8'h62 |=> regRdData == 8'h00) else $error("reserved read not zero");
   rd_hold_a: assert property (
      !regRdEn |=> $stable(regRdData)) else $error("read data moved without strobe");
   align_refuse_a: assert property (
      alignActive |-> !sampleReady) else $error("sample taken during alignment");
   off_refuse_a: assert property (
      linkDisabled |-> !sampleReady) else $error("sample taken while disabled");
   lane_hold_a: assert property (
      laneValid && !laneReady |=> laneValid && $stable(laneData)) else $error("lane word dropped");
   sync_inv_a: assert property (
      regWrEn && regAddr == 8'h60 |=> syncInvert == $past(regWrData[6])) else $error("sync invert differs from write");
endmodule : slt_link_tx_ctrl_chk

bind slt_link_tx_ctrl slt_link_tx_ctrl_chk chk (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
   .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .laneData(laneData),
   .laneValid(laneValid), .laneReady(laneReady), .sampleReady(sampleReady), .alignActive(alignActive),
   .inject8b(inject8b), .inject10b(inject10b), .linkDisabled(linkDisabled), .frameCharDisable(frameCharDisable),
   .mfCharEnable(mfCharEnable), .transportTest(transportTest), .tailPnFill(tailPnFill), .syncInvert(syncInvert));

/* testbench/slt_lane_sink.sv */
/* Lane serialiser model: drains lane words, stalling at random.
   Assumes the bench seeds $urandom once. */
`timescale 1ns/1ps
module slt_lane_sink (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [6:0] stallPct,
   output logic laneReady
);
   // Ready moves after the falling edge so it is settled at every rising edge
   always @(negedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         laneReady <= 1'b0;
      end else begin
         laneReady <= ($urandom % 7'h64) >= stallPct;
      end
   end
endmodule : slt_lane_sink

/* testbench/slt_link_tx_ctrl_tb.sv */
/* Self-checking bench for slt_link_tx_ctrl.
   Assumes the lane sink model and the bound checker. */
`timescale 1ns/1ps
`include "slt_defs.svh"
module slt_link_tx_ctrl_tb;
   logic ref_clk = 0, resetn = 0, regWrEn = 0, regRdEn = 0, sampleValid = 0, took = 0;
   logic [7:0] regAddr = 0, regWrData = 0, regRdData;
   logic [15:0] userPatternA = 0, userPatternB = 0, sampleData = 0, laneData;
   logic sampleReady, laneValid, laneReady, alignActive, inject8b, inject10b, linkDisabled;
   logic [6:0] stall = 7'h1e;
   logic [15:0] laneQ[$], srcQ[$];
   logic [15:0] rpat[8] = '{16'hbed7, 16'h2347, 16'h6b8f, 16'hb314, 16'h5efb, 16'h3559, 16'h7da1, 16'hc6e2};
   int errorCnt = 0, nCompared = 0;

   initial forever #12.5 ref_clk = ~ref_clk;
   slt_lane_sink sink (.ref_clk(ref_clk), .resetn(resetn), .stallPct(stall), .laneReady(laneReady));
   slt_link_tx_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .userPatternA(userPatternA),
      .userPatternB(userPatternB), .sampleData(sampleData), .sampleValid(sampleValid),
      .sampleReady(sampleReady), .laneData(laneData), .laneValid(laneValid), .laneReady(laneReady),
      .alignActive(alignActive), .inject8b(inject8b), .inject10b(inject10b), .linkDisabled(linkDisabled),
      .tailPnFill(), .transportTest(), .mfCharEnable(), .frameCharDisable(), .syncInvert());

   always @(posedge ref_clk) begin
      took <= sampleValid && sampleReady;
      if (sampleValid && sampleReady) srcQ.push_back(sampleData);
      if (resetn && laneValid && laneReady) laneQ.push_back(laneData);
   end
   always @(negedge ref_clk) if (took) sampleData = $urandom;

   // ---------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic giveVerdict;
      $display("compared %0d, mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : giveVerdict

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge ref_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1;
      @(negedge ref_clk);
      regWrEn = 0;
   endtask : wr

   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(negedge ref_clk);
      regAddr = a;
      regRdEn = 1;
      @(negedge ref_clk);
      regRdEn = 0;
      chk("read data", {8'h00, regRdData}, {8'h00, exp});
   endtask : rd

   task automatic wait_words(int n);
      int k;
      for (k = 0; k < 3000 && laneQ.size() < n; k++) @(negedge ref_clk);
      if (laneQ.size() < n) begin
         errorCnt++;
         $display("unexpected word count: expected %0d, seen %0d", n, laneQ.size());
         giveVerdict();
      end
   endtask : wait_words

   // Let the last words leave the buffer before the queue is cleared
   task automatic drain;
      int k;
      repeat (2) @(negedge ref_clk);
      for (k = 0; k < 200 && laneValid; k++) @(negedge ref_clk);
      chk("buffer drained", {15'h0, laneValid}, 16'h0000);
      if (laneValid) giveVerdict();
      laneQ.delete();
   endtask : drain

   task automatic check_align(int n, bit anyCount);
      wait_words(n);
      for (int i = 0; i < n; i++)
         chk("align word", laneQ[i], {8'h1c, anyCount ? laneQ[i][7:0] : 8'(i)});
   endtask : check_align

   // Disable, drain, then enable again with the given control value
   task automatic restart(logic [7:0] c1);
      wr(`SLT_OFF_CTRL1, c1 | 8'h01);
      drain();
      repeat (20) @(negedge ref_clk);
      chk("words while disabled", 16'(laneQ.size()), 16'h0000);
      wr(`SLT_OFF_CTRL1, c1);
   endtask : restart

   // Source is idle, so a quiet converter mode leaves an empty queue before the new code
   task automatic run_pat(logic [7:0] c3, int n);
      wr(`SLT_OFF_CTRL3, 8'h00);
      drain();
      srcQ.delete();
      wr(`SLT_OFF_CTRL3, c3);
      wait_words(n);
   endtask : run_pat

   function automatic logic [15:0] expw(logic [3:0] c, int i);
      case (c)
         4'h1: return i[0] ? 16'h5555 : 16'haaaa;
         4'h2: return i[0] ? 16'h0000 : 16'hffff;
         4'h8: return rpat[i % 8];
         default: return i[0] ? userPatternB : userPatternA;
      endcase
   endfunction : expw

   // Bit stream, oldest bit first, must obey the feedback recurrence of the polynomial
   function automatic bit prbs_ok(int a, int b);
      bit s[$];
      foreach (laneQ[w]) for (int j = 15; j >= 0; j--) s.push_back(laneQ[w][j]);
      for (int n = a; n < s.size(); n++) if (s[n] != (s[n-a] ^ s[n-b])) return 0;
      return 1;
   endfunction : prbs_ok

   initial begin
      logic [7:0] offs[6] = '{8'h5f, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64};
      logic [7:0] rsts[6] = '{8'h14, 8'h10, 8'h00, 8'h00, 8'h00, `SLT_DEVICE_ID};
      logic [7:0] pats[4] = '{8'h01, 8'h02, 8'h05, 8'h28};
      int pn[3][3] = '{'{3, 23, 18}, '{4, 9, 5}, '{12, 15, 14}};
      void'($urandom(68243));
      userPatternA = $urandom;
      userPatternB = $urandom;
      repeat (4) @(negedge ref_clk);
      resetn = 1;
      wr(8'h64, 8'($urandom));
      wr(8'h62, 8'hff);
      foreach (offs[i]) rd(offs[i], rsts[i]);
      check_align(16, 0);
      chk("align flag", {15'h0, alignActive}, 16'h0000);
      $display("test reset and alignment done");
      restart(8'h1c);
      check_align(24, 1);
      chk("align flag", {15'h0, alignActive}, 16'h0001);
      restart(8'h10);
      repeat (20) @(negedge ref_clk);
      chk("align flag", {15'h0, alignActive}, 16'h0000);
      restart(8'h14);
      check_align(16, 0);
      $display("test link modes done");
      stall = 7'h00;
      foreach (pats[p]) begin
         run_pat(pats[p], 12);
         for (int i = 0; i < 12; i++) chk("pattern word", laneQ[i], expw(pats[p][3:0], i));
      end
      chk("inject flags", {14'h0, inject8b, inject10b}, 16'h0002);
      run_pat(8'h06, 2);
      repeat (30) @(negedge ref_clk);
      chk("single user count", 16'(laneQ.size()), 16'h0002);
      chk("single user word", laneQ[1], userPatternB);
      foreach (pn[p]) begin
         run_pat(8'(pn[p][0]), 8);
         chk("prbs stream", {15'h0, prbs_ok(pn[p][1], pn[p][2]) || prbs_ok(pn[p][1], pn[p][1] - pn[p][2])}, 16'h0001);
      end
      $display("test patterns done");
      stall = 7'h46;
      for (int inv = 0; inv < 2; inv++) begin
         wr(`SLT_OFF_CTRL2, inv ? 8'h12 : 8'h10);
         run_pat(inv ? 8'h18 : 8'h00, 0);
         sampleValid = 1;
         wait_words(20);
         sampleValid = 0;
         for (int i = 0; i < 20; i++) chk("converter word", laneQ[i], inv ? ~srcQ[i] : srcQ[i]);
      end
      chk("inject flags", {14'h0, inject8b, inject10b}, 16'h0001);
      $display("test converter data done");
      giveVerdict();
   end
endmodule : slt_link_tx_ctrl_tb
